// ---- rtl/csf_core.sv ----
/*
 * Status flags, program counter low byte write and table read registers.
 * Assumes the CPU core gives one-cycle strobes for each event and that the
 * program memory word is presented with a strobe when a table read ends.
 */

// Behaviour
// - Writing the low counter byte jumps within the current page.
// - Such a jump inserts one extra idle cycle.
// - Table read places the word's high byte in the high byte register.
// - Table read low byte goes to the instruction's data location.
// - Eight-bit status register holds six flags.
// - Status writes never change the sleep and watchdog flags.
// - Watchdog flag: cleared by reset, clear or sleep; set by time-out.
// - Sleep flag: cleared by reset or clear; set by sleep.
// - Carry set on add carry-out or on subtract without borrow.
// - Rotate through carry swaps the carry with the shifted-out bit.
// - Nibble carry set on low nibble carry or no nibble borrow.
// - Zero flag set when an add, subtract or logic result is zero; rotates keep it.
// - Range flag set when carry into and out of bit seven differ.
// - Calls and interrupts do not save the status register.
module csf_core
    import csf_pkg::*;
(
    // Clock and reset
    input wire logic REF_CLK,
    input wire logic RST,
    // Program counter
    input wire logic [12:0] PC_IN,
    input wire logic JUMP_LOW_WE,
    input wire logic [7:0] JUMP_LOW_WDATA,
    output logic JUMP_VALID,
    output logic [12:0] JUMP_ADDR,
    output logic STALL,
    // Lookup table
    input wire logic LOOKUP_PTR_WE,
    input wire logic [7:0] LOOKUP_PTR_WDATA,
    input wire logic LOOKUP_PTR_INC,
    input wire logic LOOKUP_PTR_DEC,
    input wire logic TABLE_DONE,
    input wire logic [15:0] TABLE_WORD,
    output logic [7:0] LOOKUP_POINTER,
    output logic [7:0] LOOKUP_HIGH_BYTE,
    output logic TABLE_LOW_VALID,
    output logic [7:0] TABLE_LOW_DATA,
    // Status register access
    input wire logic FLAGS_WE,
    input wire logic [7:0] FLAGS_WDATA,
    output logic [7:0] CPU_FLAGS,
    // Datapath operation
    input wire logic OP_VALID,
    input wire logic [2:0] OP_CODE,
    input wire logic [7:0] OP_A,
    input wire logic [7:0] OP_B,
    output logic [7:0] OP_RESULT,
    // System events
    input wire logic WATCHDOG_CLEAR_INSTRUCTION,
    input wire logic SLEEP_INSTRUCTION,
    input wire logic WATCHDOG_TIMEOUT
);

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [3:0] arith_ff;
    logic sleep_ff;
    logic wdog_ff;
    logic [3:0] nxt_arith;
    logic [7:0] nxt_result;
    logic [7:0] ptr_ff;
    logic [7:0] high_ff;
    logic [7:0] low_ff;
    logic low_valid_ff;
    logic jump_valid_ff;
    logic [12:0] jump_addr_ff;
    logic [7:0] result_ff;
    csf_jump_e jump_state_ff;

    // ------------------------------------------------------------------
    // Jump through the low counter byte
    // ------------------------------------------------------------------
    // Only the low byte is replaced, so the target stays in the current page.
    always_ff @(posedge REF_CLK)
    begin
        if (RST)
        begin
            jump_valid_ff <= 1'b0;
            jump_addr_ff <= '0;
        end
        else
        begin
            jump_valid_ff <= JUMP_LOW_WE;
            if (JUMP_LOW_WE)
            begin
                jump_addr_ff <= {PC_IN[PC_W-1:DATA_W], JUMP_LOW_WDATA};
            end
        end
    end

    // One dummy cycle follows every jump write.
    always_ff @(posedge REF_CLK)
    begin
        if (RST)
        begin
            jump_state_ff <= CSF_RUN;
        end
        else
        begin
            case (jump_state_ff)
                CSF_RUN: if (JUMP_LOW_WE) jump_state_ff <= CSF_IDLE;
                CSF_IDLE: if (!JUMP_LOW_WE) jump_state_ff <= CSF_RUN;
                default: jump_state_ff <= CSF_RUN;
            endcase
        end
    end

    assign JUMP_VALID = jump_valid_ff;
    assign JUMP_ADDR = jump_addr_ff;
    assign STALL = (jump_state_ff == CSF_IDLE);

    // ------------------------------------------------------------------
    // Lookup table registers
    // ------------------------------------------------------------------
    // Pointer is written by software and stepped by increment or decrement.
    always_ff @(posedge REF_CLK)
    begin
        if (RST)
        begin
            ptr_ff <= BYTE_RST;
        end
        else if (LOOKUP_PTR_WE)
        begin
            ptr_ff <= LOOKUP_PTR_WDATA;
        end
        else if (LOOKUP_PTR_INC)
        begin
            ptr_ff <= ptr_ff + 8'h01;
        end
        else if (LOOKUP_PTR_DEC)
        begin
            ptr_ff <= ptr_ff - 8'h01;
        end
    end

    // High byte is kept; low byte is handed back for the named location.
    always_ff @(posedge REF_CLK)
    begin
        if (RST)
        begin
            high_ff <= BYTE_RST;
            low_ff <= BYTE_RST;
            low_valid_ff <= 1'b0;
        end
        else
        begin
            low_valid_ff <= TABLE_DONE;
            if (TABLE_DONE)
            begin
                high_ff <= TABLE_WORD[15:8];
                low_ff <= TABLE_WORD[7:0];
            end
        end
    end

    assign LOOKUP_POINTER = ptr_ff;
    assign LOOKUP_HIGH_BYTE = high_ff;
    assign TABLE_LOW_VALID = low_valid_ff;
    assign TABLE_LOW_DATA = low_ff;

    // ------------------------------------------------------------------
    // Flag datapath
    // ------------------------------------------------------------------
    // Computes result and arithmetic flags {range, zero, nibble, carry}.
    always_comb
    begin
        logic [8:0] sum;
        logic [4:0] nib;
        logic c7;
        sum = '0;
        nib = '0;
        c7 = 1'b0;
        nxt_result = OP_A;
        nxt_arith = arith_ff;
        case (csf_op_e'(OP_CODE))
            CSF_OP_ADD, CSF_OP_SUB:
            begin
                // Subtraction adds the complement plus one; carry means no borrow.
                if (OP_CODE == CSF_OP_SUB)
                begin
                    sum = {1'b0, OP_A} + {1'b0, ~OP_B} + 9'h001;
                    nib = {1'b0, OP_A[3:0]} + {1'b0, ~OP_B[3:0]} + 5'h01;
                    c7 = (({1'b0, OP_A[6:0]} + {1'b0, ~OP_B[6:0]} + 8'h01) >> 7) != 8'h00;
                end
                else
                begin
                    sum = {1'b0, OP_A} + {1'b0, OP_B};
                    nib = {1'b0, OP_A[3:0]} + {1'b0, OP_B[3:0]};
                    c7 = (({1'b0, OP_A[6:0]} + {1'b0, OP_B[6:0]}) >> 7) != 8'h00;
                end
                nxt_result = sum[7:0];
                nxt_arith[BIT_CARRY] = sum[8];
                nxt_arith[BIT_NIBBLE] = nib[4];
                nxt_arith[BIT_ZERO] = (sum[7:0] == 8'h00);
                nxt_arith[BIT_RANGE] = c7 ^ sum[8];
            end
            CSF_OP_LOGIC:
            begin
                nxt_result = OP_A & OP_B;
                nxt_arith[BIT_ZERO] = (nxt_result == 8'h00);
            end
            CSF_OP_RLC:
            begin
                nxt_result = {OP_A[6:0], arith_ff[BIT_CARRY]};
                nxt_arith[BIT_CARRY] = OP_A[7];
            end
            CSF_OP_RRC:
            begin
                nxt_result = {arith_ff[BIT_CARRY], OP_A[7:1]};
                nxt_arith[BIT_CARRY] = OP_A[0];
            end
            default: nxt_result = OP_A;
        endcase
    end

    always_ff @(posedge REF_CLK)
    begin
        if (RST)
        begin
            result_ff <= BYTE_RST;
        end
        else if (OP_VALID)
        begin
            result_ff <= nxt_result;
        end
    end

    assign OP_RESULT = result_ff;

    // ------------------------------------------------------------------
    // Status register
    // ------------------------------------------------------------------
    // Arithmetic flags; reset value is undefined, zero is used here.
    always_ff @(posedge REF_CLK)
    begin
        if (RST)
        begin
            arith_ff <= FLAGS_RST[3:0];
        end
        else if (OP_VALID)
        begin
            arith_ff <= nxt_arith;
        end
        else if (FLAGS_WE)
        begin
            arith_ff <= FLAGS_WDATA[3:0];
        end
    end

    // Sleep flag ignores status writes; clear instruction wins over sleep.
    always_ff @(posedge REF_CLK)
    begin
        if (RST)
        begin
            sleep_ff <= FLAGS_RST[BIT_SLEEP];
        end
        else if (WATCHDOG_CLEAR_INSTRUCTION)
        begin
            sleep_ff <= 1'b0;
        end
        else if (SLEEP_INSTRUCTION)
        begin
            sleep_ff <= 1'b1;
        end
    end

    // Watchdog flag: a time-out in the same cycle as a clear still sets it.
    always_ff @(posedge REF_CLK)
    begin
        if (RST)
        begin
            wdog_ff <= FLAGS_RST[BIT_WDOG];
        end
        else if (WATCHDOG_TIMEOUT)
        begin
            wdog_ff <= 1'b1;
        end
        else if (WATCHDOG_CLEAR_INSTRUCTION || SLEEP_INSTRUCTION)
        begin
            wdog_ff <= 1'b0;
        end
    end

    // Bits six and seven read as zero; no stack save path exists.
    assign CPU_FLAGS = {2'b00, wdog_ff, sleep_ff, arith_ff};

endmodule : csf_core

// ---- rtl/csf_pkg.sv ----
/*
 * Constants for the CPU flag and program counter low byte block.
 * Assumes a single 200 MHz clock and a synchronous active-high reset.
 */
package csf_pkg;

    // ------------------------------------------------------------------
    // Status register bit positions
    // ------------------------------------------------------------------
    localparam int unsigned BIT_CARRY = 0;
    localparam int unsigned BIT_NIBBLE = 1;
    localparam int unsigned BIT_ZERO = 2;
    localparam int unsigned BIT_RANGE = 3;
    localparam int unsigned BIT_SLEEP = 4;
    localparam int unsigned BIT_WDOG = 5;

    // ------------------------------------------------------------------
    // Widths and reset values
    // ------------------------------------------------------------------
    localparam int unsigned DATA_W = 8;
    localparam int unsigned PC_W = 13;
    localparam logic [7:0] FLAGS_RST = 8'h00;
    localparam logic [7:0] BYTE_RST = 8'h00;

    // ------------------------------------------------------------------
    // Operation codes of the flag datapath
    // ------------------------------------------------------------------
    typedef enum logic [2:0]
    {
        CSF_OP_NONE = 3'b000,
        CSF_OP_ADD = 3'b001,
        CSF_OP_SUB = 3'b010,
        CSF_OP_LOGIC = 3'b011,
        CSF_OP_RLC = 3'b100,
        CSF_OP_RRC = 3'b101
    } csf_op_e;

    // Jump sequencer states.
    typedef enum logic [0:0]
    {
        CSF_RUN = 1'b0,
        CSF_IDLE = 1'b1
    } csf_jump_e;

endpackage : csf_pkg

// ---- testbench/csf_core_checker.sv ----
/*
 * Port-level assertions for the status flag, jump and table block.
 * Assumes a single clock with synchronous active-high reset.
 */
module csf_core_checker
    import csf_pkg::*;
(
    // Clock, reset and jump
    input wire logic REF_CLK,
    input wire logic RST,
    input wire logic [12:0] PC_IN,
    input wire logic JUMP_LOW_WE,
    input wire logic [7:0] JUMP_LOW_WDATA,
    input wire logic JUMP_VALID,
    input wire logic [12:0] JUMP_ADDR,
    input wire logic STALL,
    // Table and status
    input wire logic TABLE_DONE,
    input wire logic [15:0] TABLE_WORD,
    input wire logic [7:0] LOOKUP_HIGH_BYTE,
    input wire logic TABLE_LOW_VALID,
    input wire logic [7:0] TABLE_LOW_DATA,
    input wire logic FLAGS_WE,
    input wire logic [7:0] CPU_FLAGS,
    // Events
    input wire logic WATCHDOG_CLEAR_INSTRUCTION,
    input wire logic SLEEP_INSTRUCTION,
    input wire logic WATCHDOG_TIMEOUT
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge REF_CLK);
    endclocking
    default disable iff (RST);
    logic quiet;
    // High when no system event competes with a status write.
    assign quiet = !(WATCHDOG_CLEAR_INSTRUCTION || SLEEP_INSTRUCTION || WATCHDOG_TIMEOUT);
    // A jump write followed by a cycle without a jump write.
    sequence s_jump;
        JUMP_LOW_WE ##1 !JUMP_LOW_WE;
    endsequence
    property p_jump;
        JUMP_LOW_WE |=> JUMP_VALID
            && JUMP_ADDR == {$past(PC_IN[12:8]), $past(JUMP_LOW_WDATA)};
    endproperty
    a_jump: assert property (p_jump) else $error("jump address wrong");
    property p_stall;
        s_jump |-> STALL ##1 !STALL;
    endproperty
    a_stall: assert property (p_stall) else $error("dummy cycle wrong");
    property p_high;
        TABLE_DONE |=> LOOKUP_HIGH_BYTE == $past(TABLE_WORD[15:8]);
    endproperty
    a_high: assert property (p_high) else $error("table high byte wrong");
    property p_low;
        TABLE_DONE |=> TABLE_LOW_VALID && TABLE_LOW_DATA == $past(TABLE_WORD[7:0]);
    endproperty
    a_low: assert property (p_low) else $error("table low byte wrong");
    property p_keep;
        FLAGS_WE && quiet |=> $stable(CPU_FLAGS[5:4]);
    endproperty
    a_keep: assert property (p_keep) else $error("status write hit system flags");
    property p_wd_set;
        WATCHDOG_TIMEOUT |=> CPU_FLAGS[BIT_WDOG];
    endproperty
    a_wd_set: assert property (p_wd_set) else $error("time-out flag not set");
    property p_wd_clr;
        !WATCHDOG_TIMEOUT && !quiet |=> !CPU_FLAGS[BIT_WDOG];
    endproperty
    a_wd_clr: assert property (p_wd_clr) else $error("time-out flag not cleared");
    property p_sleep;
        SLEEP_INSTRUCTION && !WATCHDOG_CLEAR_INSTRUCTION |=> CPU_FLAGS[BIT_SLEEP];
    endproperty
    a_sleep: assert property (p_sleep) else $error("sleep flag not set");
    property p_top;
        CPU_FLAGS[7:6] == 2'h0;
    endproperty
    a_top: assert property (p_top) else $error("unused status bits set");
    property p_stall_each;
        JUMP_LOW_WE |=> STALL;
    endproperty
    a_stall_each: assert property (p_stall_each) else $error("dummy cycle missing");
    property p_sleep_clr;
        WATCHDOG_CLEAR_INSTRUCTION |=> !CPU_FLAGS[BIT_SLEEP];
    endproperty
    a_sleep_clr: assert property (p_sleep_clr) else $error("sleep flag kept");
endmodule : csf_core_checker

bind csf_core csf_core_checker u_chk (
    .REF_CLK(REF_CLK), .RST(RST), .PC_IN(PC_IN), .JUMP_LOW_WE(JUMP_LOW_WE),
    .JUMP_LOW_WDATA(JUMP_LOW_WDATA), .JUMP_VALID(JUMP_VALID), .JUMP_ADDR(JUMP_ADDR),
    .STALL(STALL), .TABLE_DONE(TABLE_DONE), .TABLE_WORD(TABLE_WORD),
    .LOOKUP_HIGH_BYTE(LOOKUP_HIGH_BYTE), .TABLE_LOW_VALID(TABLE_LOW_VALID),
    .TABLE_LOW_DATA(TABLE_LOW_DATA), .FLAGS_WE(FLAGS_WE), .CPU_FLAGS(CPU_FLAGS),
    .WATCHDOG_CLEAR_INSTRUCTION(WATCHDOG_CLEAR_INSTRUCTION),
    .SLEEP_INSTRUCTION(SLEEP_INSTRUCTION), .WATCHDOG_TIMEOUT(WATCHDOG_TIMEOUT)
);

// ---- testbench/tb_cpu_status_flags_and_pc_low.sv ----
/*
 * Self-checking bench for the status flag, jump and table block.
 * Assumes the checker file is compiled alongside and binds itself.
 */
module tb_cpu_status_flags_and_pc_low
    import csf_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst, opv, jwe, td, fwe, slp, clr, wto, pw, pi, pd, jv, stall, lv;
    logic [12:0] pc, ja;
    logic [7:0] jd, pdat, fd, a, b, lp, lh, ld, flags, res;
    logic [15:0] word;
    logic [2:0] code;
    int checks = 0;
    int fail_count = 0;
    localparam logic [9:0] S_OP = 10'h200, S_JMP = 10'h100, S_TD = 10'h080, S_FW = 10'h040;
    localparam logic [9:0] S_SLP = 10'h020, S_CLR = 10'h010, S_WTO = 10'h008;
    localparam logic [9:0] S_PW = 10'h004, S_PI = 10'h002, S_PD = 10'h001;

    csf_core dut (
        .REF_CLK(clk), .RST(rst), .PC_IN(pc), .JUMP_LOW_WE(jwe), .JUMP_LOW_WDATA(jd),
        .JUMP_VALID(jv), .JUMP_ADDR(ja), .STALL(stall), .LOOKUP_PTR_WE(pw),
        .LOOKUP_PTR_WDATA(pdat), .LOOKUP_PTR_INC(pi), .LOOKUP_PTR_DEC(pd),
        .TABLE_DONE(td), .TABLE_WORD(word), .LOOKUP_POINTER(lp), .LOOKUP_HIGH_BYTE(lh),
        .TABLE_LOW_VALID(lv), .TABLE_LOW_DATA(ld), .FLAGS_WE(fwe), .FLAGS_WDATA(fd),
        .CPU_FLAGS(flags), .OP_VALID(opv), .OP_CODE(code), .OP_A(a), .OP_B(b),
        .OP_RESULT(res), .WATCHDOG_CLEAR_INSTRUCTION(clr), .SLEEP_INSTRUCTION(slp),
        .WATCHDOG_TIMEOUT(wto)
    );

    // Free-running 200 MHz clock.
    always #2.5 clk = ~clk;

    // Compares one value and counts the outcome.
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // Raises the chosen strobes for one cycle; results are settled on return.
    task automatic strobe(input logic [9:0] s);
        @(negedge clk);
        {opv, jwe, td, fwe, slp, clr, wto, pw, pi, pd} = s;
        @(negedge clk);
        {opv, jwe, td, fwe, slp, clr, wto, pw, pi, pd} = '0;
    endtask : strobe

    // Runs one datapath operation and checks flags, and result unless the code is CSF_OP_NONE.
    task automatic op(input csf_op_e c, input logic [7:0] x, y, r, f);
        code = c;
        a = x;
        b = y;
        strobe(S_OP);
        if (c != CSF_OP_NONE)
            chk("result", {8'h00, res}, {8'h00, r});
        chk("flags", {8'h00, flags}, {8'h00, f});
    endtask : op

    // Prints the counts and the verdict, then ends the run.
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : summarize

    // Cuts a hang short well beyond the expected run time.
    initial
    begin
        #4000;
        fail_count++;
        summarize();
    end

    // Main test sequence.
    initial
    begin
        rst = 1'b1;
        {opv, jwe, td, fwe, slp, clr, wto, pw, pi, pd} = '0;
        {pc, jd, pdat, fd, a, b, word, code} = '0;
        repeat (16) @(negedge clk);
        rst = 1'b0;
        chk("reset flags", 16'(flags), 16'h0000);
        chk("reset stall", 16'(stall), 16'h0000);
        $display("test reset done");
        pc = 13'h1234;
        jd = 8'h56;
        strobe(S_JMP);
        chk("jump valid", 16'(jv), 16'h0001);
        chk("jump addr", 16'(ja), 16'h1256);
        chk("stall", 16'(stall), 16'h0001);
        @(negedge clk);
        chk("stall end", 16'({jv, stall}), 16'h0000);
        // Two jump writes back to back: the second still gets its dummy cycle.
        @(negedge clk);
        jd = 8'h9a;
        jwe = 1'b1;
        @(negedge clk);
        jd = 8'hbc;
        @(negedge clk);
        jwe = 1'b0;
        chk("jump pair addr", 16'(ja), 16'h12bc);
        chk("jump pair stall", 16'(stall), 16'h0001);
        @(negedge clk);
        chk("jump pair end", 16'(stall), 16'h0000);
        $display("test jump done");
        pdat = 8'hff;
        strobe(S_PW);
        chk("pointer", 16'(lp), 16'h00ff);
        strobe(S_PI);
        chk("pointer inc", 16'(lp), 16'h0000);
        strobe(S_PD);
        chk("pointer dec", 16'(lp), 16'h00ff);
        word = 16'habcd;
        strobe(S_TD);
        chk("high byte", 16'(lh), 16'h00ab);
        chk("low data", 16'({lv, ld}), 16'h01cd);
        @(negedge clk);
        chk("low valid end", 16'(lv), 16'h0000);
        $display("test table done");
        op(CSF_OP_ADD, 8'hff, 8'h01, 8'h00, 8'h07);
        op(CSF_OP_ADD, 8'h7f, 8'h01, 8'h80, 8'h0a);
        op(CSF_OP_SUB, 8'h05, 8'h03, 8'h02, 8'h03);
        op(CSF_OP_SUB, 8'h03, 8'h05, 8'hfe, 8'h00);
        op(CSF_OP_LOGIC, 8'hf0, 8'h0f, 8'h00, 8'h04);
        op(CSF_OP_RLC, 8'h80, 8'h00, 8'h00, 8'h05);
        op(CSF_OP_RRC, 8'h00, 8'h00, 8'h80, 8'h04);
        op(CSF_OP_NONE, 8'h12, 8'h34, 8'h00, 8'h04);
        $display("test operations done");
        fd = 8'hff;
        strobe(S_FW);
        chk("status write", 16'(flags), 16'h000f);
        strobe(S_SLP);
        chk("sleep", 16'(flags), 16'h001f);
        strobe(S_WTO);
        chk("time-out", 16'(flags), 16'h003f);
        fd = 8'h00;
        strobe(S_FW);
        chk("write keeps", 16'(flags), 16'h0030);
        strobe(S_CLR);
        chk("clear", 16'(flags), 16'h0000);
        strobe(S_WTO);
        strobe(S_SLP);
        chk("sleep clears", 16'(flags), 16'h0010);
        strobe(S_WTO | S_CLR | S_SLP);
        chk("set wins", 16'(flags), 16'h0020);
        // An operation in the same cycle as a status write takes precedence.
        fd = 8'h0f;
        code = CSF_OP_LOGIC;
        a = 8'h01;
        b = 8'h01;
        strobe(S_OP | S_FW);
        chk("op beats write", 16'(flags), 16'h0020);
        chk("op beats result", 16'(res), 16'h0001);
        strobe(S_SLP | S_WTO);
        chk("both set", 16'(flags), 16'h0030);
        $display("test events done");
        // A reset in mid-run clears both system flags and all pulses.
        rst = 1'b1;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        chk("second reset", 16'({stall, lv, flags}), 16'h0000);
        $display("test second reset done");
        summarize();
    end
endmodule : tb_cpu_status_flags_and_pc_low
